// ### bench/usart_clock_gen_props.sv
// Purpose: Port checks for usart_clock_gen
// Assumes: Registers change only through APB writes
// Notes: Ctrl and divisor are shadowed from the bus
`timescale 1ns/1ns
`default_nettype none
module usart_clock_gen_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic xck_in,
	input wire logic xck_out,
	input wire logic xck_oe,
	input wire logic tx_bit_tick,
	input wire logic tx_change,
	input wire logic rx_sample_tick,
	input wire logic rx_sync_sample,
	input wire logic rx_state_wrap,
	input wire logic [3:0] rx_state,
	input wire logic [1:0] mode
);
	logic wr;
	logic [4:0] ctrl_q;
	logic [11:0] div_q;
	logic [12:0] gap_q;
	logic [4:0] nb_q;
	logic ok_q, okb_q;
	assign wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= clkgen_pkg::CTRL_RESET;
			div_q <= clkgen_pkg::DIV_RESET;
		end else if (wr && paddr == clkgen_pkg::OFS_CTRL) begin
			ctrl_q <= pwdata[4:0];
		end else if (wr && paddr == clkgen_pkg::OFS_DIV_LO) begin
			div_q[7:0] <= pwdata[7:0];
		end else if (wr && paddr == clkgen_pkg::OFS_DIV_HI) begin
			div_q[11:8] <= pwdata[3:0];
		end
	end
	////////////////////////////////////////////////////////////////
	// Spacing is judged only between two strobes with no write between
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= '0;
			nb_q <= '0;
			ok_q <= 1'b0;
			okb_q <= 1'b0;
		end else begin
			gap_q <= rx_sample_tick ? 13'h0000 : gap_q + 13'h0001;
			nb_q <= (tx_bit_tick ? 5'h00 : nb_q) + {4'h0, rx_sample_tick};
			ok_q <= !wr && (rx_sample_tick || ok_q);
			okb_q <= !wr && (tx_bit_tick || okb_q);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_tick_period: assert property (rx_sample_tick && ok_q |-> gap_q == {1'b0, div_q})
		else $error("baud tick spacing wrong");
	a_tx_div: assert property (tx_bit_tick && okb_q && !mode[1] |-> nb_q == (mode[0] ? 5'h08 : 5'h10))
		else $error("tx bit divide wrong");
	a_power_gate: assert property (ctrl_q[4] |-> !rx_sample_tick)
		else $error("tick while power reduced");
	a_mode_map: assert property (mode == {ctrl_q[0], ctrl_q[0] ? !ctrl_q[2] : ctrl_q[1]})
		else $error("mode decode wrong");
	a_pin_drive: assert property (xck_oe == (mode == 2'b10))
		else $error("pin drive wrong");
	a_sync_strobes: assert property (tx_change || rx_sync_sample |-> mode[1] || $past(mode[1]))
		else $error("sync strobe outside sync mode");
	a_edge_split: assert property (!(tx_change && rx_sync_sample))
		else $error("change and sample together");
	a_slave_edge: assert property (mode == 2'b11 && $rose(xck_in) |-> ##[2:6] (ctrl_q[3] ? rx_sync_sample : tx_change))
		else $error("slave edge strobe wrong");
	a_state_wrap: assert property (rx_state_wrap |-> rx_state == 4'h0)
		else $error("recovery wrap without state return");
	c_double: cover property (tx_bit_tick && mode == 2'b01);
	c_slave: cover property (tx_change && mode == 2'b11);
	c_master: cover property (rx_sync_sample && xck_oe);
endmodule : usart_clock_gen_props
bind usart_clock_gen usart_clock_gen_props i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .xck_in(xck_in), .xck_out(xck_out),
	.xck_oe(xck_oe), .tx_bit_tick(tx_bit_tick), .tx_change(tx_change),
	.rx_sample_tick(rx_sample_tick), .rx_sync_sample(rx_sync_sample),
	.rx_state_wrap(rx_state_wrap), .rx_state(rx_state), .mode(mode));
`default_nettype wire

// ### bench/usart_clock_generation_tb_top.sv
// Purpose: Self-checking bench for usart_clock_gen
// Assumes: Zero-wait APB slave
// Notes: Async divisors 12'h100 or random with a fixed seed, master divisor 3
`timescale 1ns/1ns
`default_nettype none
module usart_clock_generation_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, q;
	logic pready, pslverr, xck_in, xck_out, xck_oe, tx_bit_tick, tx_change;
	logic rx_sample_tick, rx_sync_sample, rx_state_wrap, err, dbl;
	logic [3:0] rx_state;
	logic [1:0] mode;
	logic [11:0] d;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 32'he6235f34;
	int g, n_chg, n_smp, n_tk, first;
	always #10 pclk = ~pclk;
	usart_clock_gen i_usart_clock_gen (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .xck_in(xck_in),
		.xck_out(xck_out), .xck_oe(xck_oe), .tx_bit_tick(tx_bit_tick),
		.tx_change(tx_change), .rx_sample_tick(rx_sample_tick),
		.rx_sync_sample(rx_sync_sample), .rx_state_wrap(rx_state_wrap),
		.rx_state(rx_state), .mode(mode));
	xck_peer i_xck_peer (.pclk(pclk), .xck(xck_in));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Strobes are looked at on the falling edge, clear of update races
	task automatic gap(input logic sel, output int c);
		c = 0;
		do @(negedge pclk); while ((sel ? tx_bit_tick : rx_sample_tick) !== 1'b1);
		do begin
			@(negedge pclk);
			c++;
		end while ((sel ? tx_bit_tick : rx_sample_tick) !== 1'b1);
		@(posedge pclk);
	endtask : gap
	function automatic logic [31:0] tx_gap(input logic db, input logic [11:0] dv);
		return (db ? 32'h8 : 32'h10) * ({20'h0, dv} + 32'h1);
	endfunction : tx_gap
	always @(negedge pclk) begin
		if (tx_change === 1'b1) n_chg++;
		if (rx_sync_sample === 1'b1) n_smp++;
		if (rx_sample_tick === 1'b1) n_tk++;
		if (first == 0 && tx_change === 1'b1) first = 1;
		if (first == 0 && rx_sync_sample === 1'b1) first = 2;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (90000) @(posedge pclk);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		n_tk = 0;
		apb(1'b0, clkgen_pkg::OFS_CTRL, 32'h0);
		chk("ctrl reset", q, {27'h0, clkgen_pkg::CTRL_RESET});
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", q, 32'h0);
		chk("held ticks", n_tk, 32'h0);
		for (int m = 0; m < 6; m++) begin
			dbl = (m > 2);
			d = (m % 3 == 0) ? 12'h100 : 12'($random(seed)) & 12'h10f;
			apb(1'b1, clkgen_pkg::OFS_DIV_HI, {28'h0, d[11:8]});
			apb(1'b1, clkgen_pkg::OFS_DIV_LO, {24'h0, d[7:0]});
			apb(1'b1, clkgen_pkg::OFS_CTRL, {30'h0, dbl, 1'b0});
			chk("async mode", {30'h0, mode}, {31'h0, dbl});
			gap(1'b0, g);
			chk("tick gap", g, {20'h0, d} + 32'h1);
			gap(1'b1, g);
			chk("bit gap", g, tx_gap(dbl, d));
		end
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, clkgen_pkg::OFS_CTRL, p ? 32'h9 : 32'h1);
			chk("slave mode", {30'h0, mode}, 32'h3);
			chk("slave drive", {31'h0, xck_oe}, 32'h0);
			n_chg = 0;
			n_smp = 0;
			first = 0;
			i_xck_peer.frame(4);
			repeat (8) @(posedge pclk);
			chk("change count", n_chg, 32'h4);
			chk("sample count", n_smp, 32'h4);
			chk("first edge", first, p ? 32'h2 : 32'h1);
		end
		apb(1'b1, clkgen_pkg::OFS_DIV_HI, 32'h0);
		apb(1'b1, clkgen_pkg::OFS_DIV_LO, 32'h3);
		apb(1'b1, clkgen_pkg::OFS_CTRL, 32'h5);
		chk("master mode", {30'h0, mode}, 32'h2);
		chk("master drive", {31'h0, xck_oe}, 32'h1);
		gap(1'b1, g);
		chk("master bit gap", g, 32'h8);
		n_chg = 0;
		n_smp = 0;
		repeat (40) @(posedge pclk);
		chk("master strobes", {31'h0, n_chg > 0 && n_smp > 0}, 32'h1);
		report_and_stop;
	end
endmodule : usart_clock_generation_tb_top
`default_nettype wire

// ### bench/xck_peer.sv
// Purpose: Far party supplying the transfer clock
// Assumes: Bench calls frame() right after a pclk edge
// Notes: Clock rests low between frames
`timescale 1ns/1ns
`default_nettype none
module xck_peer (
	input wire logic pclk,
	output logic xck
);
	initial xck = 1'b0;
	// Period of 12 pclk stays well under a quarter of pclk
	task automatic frame(input int n);
		repeat (n) begin
			repeat (6) @(posedge pclk);
			xck <= 1'b1;
			repeat (6) @(posedge pclk);
			xck <= 1'b0;
		end
	endtask : frame
endmodule : xck_peer
`default_nettype wire

// ### src/baud_counter.sv
// Purpose: Programmable down-counter producing baud ticks
// Assumes: Runs on the system clock
// Notes: Tick rate is clock over divisor plus one
`timescale 1ns/1ns
`default_nettype none
module baud_counter #(
	parameter int WIDTH = clkgen_pkg::DIV_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic [WIDTH-1:0] divisor,
	input wire logic reload,
	output logic tick
);
	logic [WIDTH-1:0] count_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (reload || !enable) begin
			count_q <= divisor; // [R4]
		end else if (count_q == '0) begin
			count_q <= divisor; // [R4]
		end else begin
			count_q <= count_q - 1'b1;
		end
	end

	// Zero reached while running; a reload in that cycle suppresses the tick
	assign tick = enable && !reload && (count_q == '0); // [R5]
endmodule : baud_counter
`default_nettype wire

// ### src/clkgen_pkg.sv
// Purpose: Shared constants for the serial port clock generator
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
//
// Functional notes
// [R1] - The generator offers normal async, double-speed async, sync master and sync slave modes, chosen by sync_mode_select.
// [R2] - In sync mode the transfer clock pin direction picks the internal generator when output and the external pin clock when input.
// [R3] - The transfer clock pin is used only in sync mode, as an input for a slave and as a driven output for a master.
// [R4] - A down-counter on the system clock reloads from the divisor at zero and whenever the low divisor byte is written.
// [R5] - One baud tick is emitted each time the counter reaches zero, giving system clock over divisor plus one.
// [R6] - The transmit bit clock is the baud tick divided by 16 in normal async, 8 in double-speed async and 2 in sync master.
// [R7] - Receive recovery takes the baud tick directly and steps through 2, 8 or 16 states chosen by the mode bits.
// [R8] - The divisor is 12 bits built from high and low parts, legal from 0 to 4095.
// [R9] - Double speed in async mode cuts the divider from 16 to 8 and the receiver uses 8 samples per bit.
// [R10] - Software keeps double speed cleared in sync mode; the bit has no effect outside async mode.
// [R11] - In slave mode the external clock passes a synchroniser and an edge detector, adding two system clock periods; the code adds four.
// [R12] - The far party keeps the supplied transfer clock below a quarter of the system clock, with margin.
// [R13] - In sync mode receive data is sampled on the transfer clock edge opposite to the one where transmit data changes.
// [R14] - With polarity clear data changes on the rising edge and is sampled on the falling edge; set swaps them.
// [R15] - Software writes the power reduction bit to zero before using the port.
package clkgen_pkg;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_DIV_LO = 12'h004;
	localparam logic [11:0] OFS_DIV_HI = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_DOUBLE = 1;
	localparam int CTRL_PIN_OUT = 2;
	localparam int CTRL_POLARITY = 3;
	localparam int CTRL_POWER_RED = 4;
	localparam logic [4:0] CTRL_RESET = 5'h10;
	localparam logic [11:0] DIV_RESET = 12'h000;
	localparam int DIV_WIDTH = 12;
	localparam logic [3:0] STATES_NORMAL = 4'hf;
	localparam logic [3:0] STATES_DOUBLE = 4'h7;
	localparam logic [3:0] STATES_SYNC = 4'h1;
	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b00,
		MODE_ASYNC_2X = 2'b01,
		MODE_SYNC_MASTER = 2'b10,
		MODE_SYNC_SLAVE = 2'b11
	} clk_mode_e;
endpackage : clkgen_pkg

// ### src/usart_clock_gen.sv
// Purpose: Clock generation for the serial port: baud divider, four modes, pin clock
// Assumes: APB slave, 32-bit data, single pclk domain
// Notes: Tick and strobe outputs are single-cycle strobes for the shifters
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module usart_clock_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic xck_in,
	output logic xck_out,
	output logic xck_oe,
	output logic tx_bit_tick,
	output logic tx_change,
	output logic rx_sample_tick,
	output logic rx_sync_sample,
	output logic rx_state_wrap,
	output logic [3:0] rx_state,
	output logic [1:0] mode
);
	////////////////////////////////////////////////////////////////////
	// Register file
	logic [4:0] ctrl_q;
	logic [11:0] div_q;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	assign addr_ok = (paddr == clkgen_pkg::OFS_CTRL) || (paddr == clkgen_pkg::OFS_DIV_LO)
		|| (paddr == clkgen_pkg::OFS_DIV_HI) || (paddr == clkgen_pkg::OFS_STATUS);
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= clkgen_pkg::CTRL_RESET;
		end else if (wr_en && paddr == clkgen_pkg::OFS_CTRL) begin
			ctrl_q <= pwdata[4:0];
		end
	end

	// Both parts take effect on the next reload; a low write restarts the count at once from the old divisor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= clkgen_pkg::DIV_RESET;
		end else if (wr_en && paddr == clkgen_pkg::OFS_DIV_LO) begin
			div_q[7:0] <= pwdata[7:0]; // [R8]
		end else if (wr_en && paddr == clkgen_pkg::OFS_DIV_HI) begin
			div_q[11:8] <= pwdata[3:0]; // [R8]
		end
	end

	logic sync_sel;
	logic dbl;
	logic pin_out;
	logic pol;
	logic pwr_red;
	assign sync_sel = ctrl_q[clkgen_pkg::CTRL_SYNC];
	assign dbl = ctrl_q[clkgen_pkg::CTRL_DOUBLE];
	assign pin_out = ctrl_q[clkgen_pkg::CTRL_PIN_OUT];
	assign pol = ctrl_q[clkgen_pkg::CTRL_POLARITY];
	assign pwr_red = ctrl_q[clkgen_pkg::CTRL_POWER_RED]; // [R15]

	////////////////////////////////////////////////////////////////////
	// Mode decode
	clkgen_pkg::clk_mode_e mode_c;
	always_comb begin
		if (!sync_sel) begin
			// Double speed is ignored in sync mode
			mode_c = dbl ? clkgen_pkg::MODE_ASYNC_2X : clkgen_pkg::MODE_ASYNC; // [R1] [R9] [R10]
		end else begin
			mode_c = pin_out ? clkgen_pkg::MODE_SYNC_MASTER : clkgen_pkg::MODE_SYNC_SLAVE; // [R2]
		end
	end
	assign mode = mode_c;

	////////////////////////////////////////////////////////////////////
	// Baud generator
	logic baud_tick;
	logic div_lo_wr;
	assign div_lo_wr = wr_en && (paddr == clkgen_pkg::OFS_DIV_LO);

	baud_counter #(
		.WIDTH(clkgen_pkg::DIV_WIDTH)
	) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.enable(!pwr_red),
		.divisor(div_q),
		.reload(div_lo_wr),
		.tick(baud_tick)
	);

	////////////////////////////////////////////////////////////////////
	// Receiver recovery state counter driven straight by the baud tick
	logic [3:0] last_state;
	logic [3:0] rx_state_q;
	always_comb begin
		case (mode_c)
			clkgen_pkg::MODE_ASYNC: last_state = clkgen_pkg::STATES_NORMAL;
			clkgen_pkg::MODE_ASYNC_2X: last_state = clkgen_pkg::STATES_DOUBLE;
			default: last_state = clkgen_pkg::STATES_SYNC;
		endcase
	end

	// Mode change returns an out-of-range state to 0 so a shorter cycle cannot overrun
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_q <= 4'h0;
		end else if (rx_state_q > last_state) begin
			rx_state_q <= 4'h0;
		end else if (baud_tick && mode_c != clkgen_pkg::MODE_SYNC_SLAVE) begin
			rx_state_q <= (rx_state_q == last_state) ? 4'h0 : rx_state_q + 4'h1; // [R7]
		end
	end
	assign rx_state = rx_state_q;
	assign rx_sample_tick = baud_tick && !sync_sel; // [R7]

	////////////////////////////////////////////////////////////////////
	// Transmit divider: 16, 8 or 2 baud ticks per bit
	logic [3:0] tx_div_q;
	logic tx_wrap;
	assign tx_wrap = baud_tick && (tx_div_q == last_state);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_div_q <= 4'h0;
		end else if (tx_div_q > last_state) begin
			tx_div_q <= 4'h0;
		end else if (baud_tick) begin
			tx_div_q <= tx_wrap ? 4'h0 : tx_div_q + 4'h1; // [R6] [R9]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Master clock: toggles on every baud tick, so one bit per two ticks
	logic xck_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xck_q <= 1'b0;
		end else if (mode_c != clkgen_pkg::MODE_SYNC_MASTER) begin
			xck_q <= pol; // Idle at the level that makes the first edge a change edge
		end else if (baud_tick) begin
			xck_q <= !xck_q; // [R6]
		end
	end

	// Pin only driven in master mode; slaves and async leave it as input
	assign xck_out = xck_q; // [R3]
	assign xck_oe = (mode_c == clkgen_pkg::MODE_SYNC_MASTER); // [R3] [R2]

	logic m_rise;
	logic m_fall;
	assign m_rise = (mode_c == clkgen_pkg::MODE_SYNC_MASTER) && baud_tick && !xck_q;
	assign m_fall = (mode_c == clkgen_pkg::MODE_SYNC_MASTER) && baud_tick && xck_q;

	////////////////////////////////////////////////////////////////////
	// Slave clock path
	logic s_level;
	logic s_rise;
	logic s_fall;
	xck_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(xck_in),
		.level(s_level),
		.rise(s_rise),
		.fall(s_fall)
	);

	logic slave;
	logic e_rise;
	logic e_fall;
	assign slave = (mode_c == clkgen_pkg::MODE_SYNC_SLAVE); // [R11]
	assign e_rise = slave ? s_rise : m_rise;
	assign e_fall = slave ? s_fall : m_fall;

	////////////////////////////////////////////////////////////////////
	// Strobes
	logic tx_bit_q;
	logic tx_chg_q;
	logic rx_smp_q;
	logic wrap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_bit_q <= 1'b0;
			tx_chg_q <= 1'b0;
			rx_smp_q <= 1'b0;
			wrap_q <= 1'b0;
		end else begin
			tx_bit_q <= sync_sel ? (pol ? e_fall : e_rise) : tx_wrap; // [R6] [R14]
			tx_chg_q <= sync_sel && (pol ? e_fall : e_rise); // [R14] [R13]
			rx_smp_q <= sync_sel && (pol ? e_rise : e_fall); // [R14] [R13]
			wrap_q <= baud_tick && (rx_state_q == last_state) && !slave;
		end
	end
	assign tx_bit_tick = tx_bit_q;
	assign tx_change = tx_chg_q;
	assign rx_sync_sample = rx_smp_q;
	assign rx_state_wrap = wrap_q;

	////////////////////////////////////////////////////////////////////
	// Read mux; status shows mode, pin clock level and recovery state
	logic [31:0] rd_c;
	always_comb begin
		rd_c = 32'h0000_0000;
		case (paddr)
			clkgen_pkg::OFS_CTRL: rd_c = {27'h0, ctrl_q};
			clkgen_pkg::OFS_DIV_LO: rd_c = {24'h0, div_q[7:0]};
			clkgen_pkg::OFS_DIV_HI: rd_c = {28'h0, div_q[11:8]};
			clkgen_pkg::OFS_STATUS: rd_c = {24'h0, rx_state_q, s_level, xck_q, mode_c};
			default: rd_c = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_c;
		end
	end
	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : usart_clock_gen
`default_nettype wire

// ### src/xck_sync.sv
// Purpose: Synchroniser and edge detector for the external transfer clock
// Assumes: Pin clock well below a quarter of pclk
// Notes: Four flops, a three-stage chain plus a level flop; a level change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module xck_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin_in; // [R11]
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign level = level_q;
	assign rise = (s2_q == s3_q) && s3_q && !level_q; // [R11]
	assign fall = (s2_q == s3_q) && !s3_q && level_q; // [R11]
endmodule : xck_sync
`default_nettype wire
